// ==== frb_pkg.sv ====
// Constants, types and lookup functions of the frame rate inquiry bank.
// Assumes a 12-bit byte address space and 32-bit register words.
package frb_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam int FRB_ADDR_W = 12;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_F1M3 = 12'h22C;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_F1M5 = 12'h234;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_F1M6 = 12'h238;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_F1M7 = 12'h23C;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_F2M0 = 12'h240;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_F2M2 = 12'h248;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_F2M6 = 12'h258;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_STAT = 12'h3F8;
    localparam logic [FRB_ADDR_W-1:0] FRB_OFF_CTRL = 12'h3FC;

    // ------------------------------------------------------------
    // Capability bitmaps, bit 0 = 1.875 fps up to bit 7 = 240 fps
    // ------------------------------------------------------------
    localparam logic [7:0] FRB_CAP_F1M3_V0 = 8'h00;
    localparam logic [7:0] FRB_CAP_F1M3_V1 = 8'h0E;
    localparam logic [7:0] FRB_CAP_F1M5 = 8'h0E;
    localparam logic [7:0] FRB_CAP_F1M6 = 8'h0E;
    localparam logic [7:0] FRB_CAP_F1M7 = 8'h0E;
    localparam logic [7:0] FRB_CAP_F2M0_V0 = 8'h00;
    localparam logic [7:0] FRB_CAP_F2M0_V1 = 8'h07;
    localparam logic [7:0] FRB_CAP_F2M2 = 8'h0F;
    localparam logic [7:0] FRB_CAP_F2M6 = 8'h07;

    // ------------------------------------------------------------
    // Own registers and reset values
    // ------------------------------------------------------------
    localparam int FRB_CTRL_STRICT_BIT = 0;
    localparam int FRB_CTRL_CLR_BIT = 1;
    localparam int FRB_STAT_CNT_LSB = 0;
    localparam int FRB_STAT_VAR_BIT = 16;
    localparam int FRB_IGN_CNT_W = 16;
    localparam logic FRB_STRICT_RST = 1'b0;
    localparam logic FRB_RDY_RST = 1'b1;
    localparam logic [1:0] FRB_RESP_OKAY = 2'h0;
    localparam logic [1:0] FRB_RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {FRB_KIND_CAP, FRB_KIND_CTRL, FRB_KIND_STAT, FRB_KIND_NONE}
        frb_kind_type;
    typedef enum logic {FRB_WR_COLLECT, FRB_WR_RESP} frb_wr_state_type;
    typedef enum logic {FRB_RD_IDLE, FRB_RD_RESP} frb_rd_state_type;

    // ------------------------------------------------------------
    // Lookup functions
    // ------------------------------------------------------------
    function automatic frb_kind_type frb_decode(input logic [FRB_ADDR_W-1:0] addr);
        logic [FRB_ADDR_W-1:0] word;
        word = {addr[FRB_ADDR_W-1:2], 2'h0};
        case (word)
            FRB_OFF_F1M3, FRB_OFF_F1M5, FRB_OFF_F1M6, FRB_OFF_F1M7,
            FRB_OFF_F2M0, FRB_OFF_F2M2, FRB_OFF_F2M6: return FRB_KIND_CAP;
            FRB_OFF_CTRL: return FRB_KIND_CTRL;
            FRB_OFF_STAT: return FRB_KIND_STAT;
            default: return FRB_KIND_NONE;
        endcase
    endfunction

    function automatic logic [31:0] frb_caps_value(input logic [FRB_ADDR_W-1:0] addr,
                                                   input logic second);
        logic [FRB_ADDR_W-1:0] word;
        logic [7:0] caps;
        word = {addr[FRB_ADDR_W-1:2], 2'h0};
        case (word)
            FRB_OFF_F1M3: caps = second ? FRB_CAP_F1M3_V1 : FRB_CAP_F1M3_V0; // RULE_03
            FRB_OFF_F1M5: caps = FRB_CAP_F1M5; // RULE_04
            FRB_OFF_F1M6: caps = FRB_CAP_F1M6; // RULE_05
            FRB_OFF_F1M7: caps = FRB_CAP_F1M7; // RULE_06
            FRB_OFF_F2M0: caps = second ? FRB_CAP_F2M0_V1 : FRB_CAP_F2M0_V0; // RULE_07
            FRB_OFF_F2M2: caps = FRB_CAP_F2M2; // RULE_08
            FRB_OFF_F2M6: caps = FRB_CAP_F2M6; // RULE_09
            default: caps = 8'h00;
        endcase
        return {24'h000000, caps}; // RULE_01 RULE_02
    endfunction

endpackage

// ==== frb_lookup_if.sv ====
// Address lookup carrier between the bank top and its lookup units.
// Assumes the lookup side is purely combinational.
`timescale 1ns/1ns
interface frb_lookup_if;
    import frb_pkg::*;
    logic [FRB_ADDR_W-1:0] addr;
    frb_kind_type kind;
    logic [31:0] caps;
    modport lookup (input addr, output kind, output caps);
    modport user (output addr, input kind, input caps);
endinterface

// ==== frb_cap_lookup.sv ====
// Address decode and capability table for one access path.
// Assumes the address is stable for the cycle in which it is used.
`timescale 1ns/1ns
module frb_cap_lookup import frb_pkg::*; #(
    parameter logic SECOND_VARIANT = 1'b0
) (
    frb_lookup_if.lookup lk
);

    // ------------------------------------------------------------
    // Decode and table
    // ------------------------------------------------------------
    always_comb begin
        lk.kind = frb_decode(lk.addr);
        lk.caps = frb_caps_value(lk.addr, SECOND_VARIANT); // RULE_01
    end

endmodule

// ==== frb_ignore_counter.sv ====
// Saturating counter of writes dropped by the read-only bank.
// Assumes increment and clear come from one write path, never together.
`timescale 1ns/1ns
module frb_ignore_counter import frb_pkg::*; #(
    parameter int CNT_W = FRB_IGN_CNT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cnt_clr,
    input wire logic cnt_inc,
    output logic [CNT_W-1:0] cnt_value
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // ------------------------------------------------------------
    // Next count, clear applied first, then increment
    // ------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        if (cnt_clr) begin
            cnt_next = '0;
        end
        if (cnt_inc && (cnt_reg != {CNT_W{1'b1}})) begin
            cnt_next = cnt_clr ? CNT_W'(1) : cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign cnt_value = cnt_reg;

endmodule

// ==== frb_bank_top.sv ====
// Frame rate inquiry register bank with an AXI4-Lite slave port.
// Assumes one clock, synchronous reset and a 32-bit AXI4-Lite master.
//
// Function
// [RULE_01] Bits 0..7 stand for 1.875, 3.75, 7.5, 15, 30, 60, 120, 240 fps.
// [RULE_02] A one means supported; zero, reserved bits and bits 8..31 read zero.
// [RULE_03] Format 1 mode 3: zero in first variant, bits 1..3 in second.
// [RULE_04] Format 1 mode 5: bits 1..3 set in both variants.
// [RULE_05] Format 1 mode 6: bit 0 reserved, bits 1..3 set, 4..7 clear.
// [RULE_06] Format 1 mode 7: bits 1..3 set, bits 0 and 4..7 clear.
// [RULE_07] Format 2 mode 0: zero in first variant, bits 0..2 in second.
// [RULE_08] Format 2 mode 2: bits 0..3 set, 4..6 clear, bit 7 reserved.
// [RULE_09] Format 2 mode 6: bits 0..2 set, 3..5 clear, 6..7 reserved.
// [RULE_10] Writes to capability registers are dropped and answered without error.
`timescale 1ns/1ns
module frb_bank_top import frb_pkg::*; #(
    parameter logic SECOND_VARIANT = 1'b0,
    parameter int CNT_W = FRB_IGN_CNT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [FRB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [FRB_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // Write path state
    // ------------------------------------------------------------
    frb_wr_state_type wr_state_reg;
    frb_wr_state_type wr_state_next;
    logic aw_got_reg;
    logic aw_got_next;
    logic w_got_reg;
    logic w_got_next;
    logic [FRB_ADDR_W-1:0] awaddr_reg;
    logic [FRB_ADDR_W-1:0] awaddr_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic [3:0] wstrb_reg;
    logic [3:0] wstrb_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic strict_reg;
    logic strict_next;

    // ------------------------------------------------------------
    // Read path state
    // ------------------------------------------------------------
    frb_rd_state_type rd_state_reg;
    frb_rd_state_type rd_state_next;
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;

    // ------------------------------------------------------------
    // Shared signals
    // ------------------------------------------------------------
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic [FRB_ADDR_W-1:0] wr_addr_sel;
    logic [31:0] wr_data_sel;
    logic [3:0] wr_strb_sel;
    logic cnt_clr;
    logic cnt_inc;
    logic [CNT_W-1:0] ign_count;
    logic [31:0] stat_word;
    logic [31:0] ctrl_word;

    frb_lookup_if wr_lk ();
    frb_lookup_if rd_lk ();

    // ------------------------------------------------------------
    // Lookup units and counter
    // ------------------------------------------------------------
    frb_cap_lookup #(
        .SECOND_VARIANT(SECOND_VARIANT)
    ) u_wr_lookup (
        .lk(wr_lk.lookup)
    );

    frb_cap_lookup #(
        .SECOND_VARIANT(SECOND_VARIANT)
    ) u_rd_lookup (
        .lk(rd_lk.lookup)
    );

    frb_ignore_counter #(
        .CNT_W(CNT_W)
    ) u_ign_cnt (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .cnt_clr(cnt_clr),
        .cnt_inc(cnt_inc),
        .cnt_value(ign_count)
    );

    // ------------------------------------------------------------
    // Handshakes and operand selection
    // ------------------------------------------------------------
    assign aw_hs = s_axi_awvalid && awready_reg;
    assign w_hs = s_axi_wvalid && wready_reg;
    assign ar_hs = s_axi_arvalid && arready_reg;
    assign wr_addr_sel = aw_hs ? s_axi_awaddr : awaddr_reg;
    assign wr_data_sel = w_hs ? s_axi_wdata : wdata_reg;
    assign wr_strb_sel = w_hs ? s_axi_wstrb : wstrb_reg;
    assign wr_lk.addr = wr_addr_sel;
    assign rd_lk.addr = s_axi_araddr;

    // ------------------------------------------------------------
    // Readable words of own registers
    // ------------------------------------------------------------
    always_comb begin
        stat_word = 32'h00000000;
        stat_word[FRB_STAT_CNT_LSB +: CNT_W] = ign_count;
        stat_word[FRB_STAT_VAR_BIT] = SECOND_VARIANT;
        ctrl_word = 32'h00000000;
        ctrl_word[FRB_CTRL_STRICT_BIT] = strict_reg;
    end

    // ------------------------------------------------------------
    // Write path next state
    // ------------------------------------------------------------
    always_comb begin
        wr_state_next = wr_state_reg;
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        awready_next = awready_reg;
        wready_next = wready_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        strict_next = strict_reg;
        cnt_clr = 1'b0;
        cnt_inc = 1'b0;
        case (wr_state_reg)
            FRB_WR_COLLECT: begin
                if (aw_hs) begin
                    aw_got_next = 1'b1;
                    awaddr_next = s_axi_awaddr;
                end
                if (w_hs) begin
                    w_got_next = 1'b1;
                    wdata_next = s_axi_wdata;
                    wstrb_next = s_axi_wstrb;
                end
                if (aw_got_next && w_got_next) begin
                    wr_state_next = FRB_WR_RESP;
                    aw_got_next = 1'b0;
                    w_got_next = 1'b0;
                    awready_next = 1'b0;
                    wready_next = 1'b0;
                    bvalid_next = 1'b1;
                    bresp_next = FRB_RESP_OKAY;
                    case (wr_lk.kind)
                        FRB_KIND_CAP: begin
                            cnt_inc = 1'b1; // RULE_10
                        end
                        FRB_KIND_CTRL: begin
                            if (wr_strb_sel[0]) begin
                                strict_next = wr_data_sel[FRB_CTRL_STRICT_BIT];
                                cnt_clr = wr_data_sel[FRB_CTRL_CLR_BIT];
                            end
                        end
                        FRB_KIND_STAT: begin
                            bresp_next = FRB_RESP_OKAY;
                        end
                        default: begin
                            bresp_next = strict_reg ? FRB_RESP_DECERR : FRB_RESP_OKAY;
                        end
                    endcase
                end else begin
                    awready_next = !aw_got_next;
                    wready_next = !w_got_next;
                end
            end
            FRB_WR_RESP: begin
                if (s_axi_bready && bvalid_reg) begin
                    wr_state_next = FRB_WR_COLLECT;
                    bvalid_next = 1'b0;
                    awready_next = 1'b1;
                    wready_next = 1'b1;
                end
            end
            default: begin
                wr_state_next = FRB_WR_COLLECT;
                bvalid_next = 1'b0;
                awready_next = 1'b1;
                wready_next = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Write path registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_state_reg <= FRB_WR_COLLECT;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            awready_reg <= FRB_RDY_RST;
            wready_reg <= FRB_RDY_RST;
            bvalid_reg <= 1'b0;
            bresp_reg <= FRB_RESP_OKAY;
            strict_reg <= FRB_STRICT_RST;
        end else begin
            wr_state_reg <= wr_state_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            strict_reg <= strict_next;
        end
    end

    // ------------------------------------------------------------
    // Read path next state
    // ------------------------------------------------------------
    always_comb begin
        rd_state_next = rd_state_reg;
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rd_state_reg)
            FRB_RD_IDLE: begin
                if (ar_hs) begin
                    rd_state_next = FRB_RD_RESP;
                    arready_next = 1'b0;
                    rvalid_next = 1'b1;
                    rresp_next = FRB_RESP_OKAY;
                    case (rd_lk.kind)
                        FRB_KIND_CAP: begin
                            rdata_next = rd_lk.caps; // RULE_01 RULE_02
                        end
                        FRB_KIND_CTRL: begin
                            rdata_next = ctrl_word;
                        end
                        FRB_KIND_STAT: begin
                            rdata_next = stat_word;
                        end
                        default: begin
                            rdata_next = 32'h00000000;
                            rresp_next = strict_reg ? FRB_RESP_DECERR : FRB_RESP_OKAY;
                        end
                    endcase
                end
            end
            FRB_RD_RESP: begin
                if (s_axi_rready && rvalid_reg) begin
                    rd_state_next = FRB_RD_IDLE;
                    rvalid_next = 1'b0;
                    arready_next = 1'b1;
                end
            end
            default: begin
                rd_state_next = FRB_RD_IDLE;
                rvalid_next = 1'b0;
                arready_next = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read path registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_state_reg <= FRB_RD_IDLE;
            arready_reg <= FRB_RDY_RST;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= FRB_RESP_OKAY;
        end else begin
            rd_state_reg <= rd_state_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule

// ==== frb_bank_asserts.sv ====
// Concurrent checks on the AXI4-Lite port of the frame rate inquiry bank.
// Assumes one clock and an active high synchronous reset.
`timescale 1ns/1ns
module frb_bank_asserts import frb_pkg::*; #(
    parameter logic SECOND_VARIANT = 1'b0,
    parameter int CNT_W = FRB_IGN_CNT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [FRB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [FRB_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // Taken addresses and their expected contents
    // ------------------------------------------------------------
    logic [FRB_ADDR_W-1:0] ar_reg, ar_next, aw_reg, aw_next;
    logic [8:0] ar_cap, aw_cap;

    function automatic logic [8:0] cap_of(input logic [FRB_ADDR_W-1:0] a);
        case ({a[11:2], 2'h0})
            12'h22C: return {1'b1, SECOND_VARIANT ? 8'h0E : 8'h00};
            12'h234, 12'h238, 12'h23C: return 9'h10E;
            12'h240: return {1'b1, SECOND_VARIANT ? 8'h07 : 8'h00};
            12'h248: return 9'h10F;
            12'h258: return 9'h107;
            default: return 9'h000;
        endcase
    endfunction

    always_comb begin
        ar_next = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_reg;
        aw_next = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_reg;
        ar_cap = cap_of(ar_reg);
        aw_cap = cap_of(aw_reg);
    end

    always_ff @(posedge core_clk) begin
        ar_reg <= sys_rst ? '0 : ar_next;
        aw_reg <= sys_rst ? '0 : aw_next;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed");
    rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready)
        else $error("read answer not released");
    cap_value_a: assert property (
        s_axi_rvalid && ar_cap[8] |-> s_axi_rdata == {24'h000000, ar_cap[7:0]}
        && s_axi_rresp == FRB_RESP_OKAY)
        else $error("capability read wrong");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("write answer late");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer changed");
    cap_write_ok_a: assert property (s_axi_bvalid && aw_cap[8] |->
        s_axi_bresp == FRB_RESP_OKAY)
        else $error("capability write refused");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");

    cap_rd_c: cover property (s_axi_rvalid && s_axi_rready && ar_cap[8]);
    cap_wr_c: cover property (s_axi_bvalid && s_axi_bready && aw_cap[8]);
    decerr_c: cover property (s_axi_rvalid && s_axi_rresp == FRB_RESP_DECERR);
endmodule

bind frb_bank_top frb_bank_asserts #(.SECOND_VARIANT(SECOND_VARIANT), .CNT_W(CNT_W)) u_chk (.*);

// ==== frb_host_model.sv ====
// Host software model: an AXI4-Lite master reading and writing registers.
// Assumes tasks are called from one process per channel.
`timescale 1ns/1ns
module frb_host_model import frb_pkg::*; (
    input wire logic core_clk,
    output logic [FRB_ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [FRB_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic hung
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
    end

    // ------------------------------------------------------------
    // Write: address and data together, released lines scrambled
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        bit done;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom_range(1));
        done = 0;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end else if (s_axi_bvalid) begin
                s_axi_bready <= 1'b1;
            end
        end
        if (!done) hung <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Read: one word, answer taken with rready high
    // ------------------------------------------------------------
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom_range(1));
        done = 0;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end else if (s_axi_rvalid) begin
                s_axi_rready <= 1'b1;
            end
        end
        if (!done) hung <= 1'b1;
    endtask
endmodule

// ==== frame_rate_inquiry_bank_tb_top.sv ====
// Self-checking bench of the frame rate inquiry bank, second variant.
// Assumes the host model drives the bus and a table model gives expectations.
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module frame_rate_inquiry_bank_tb_top import frb_pkg::*;;
    localparam logic SV = 1'b1;
    logic core_clk, sys_rst, hung;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_errors = 0;
    int cmp_count = 0;
    int cnt = 0;
    logic [11:0] caps [7] = '{12'h22C, 12'h234, 12'h238, 12'h23C, 12'h240, 12'h248, 12'h258};
    logic [31:0] exp_cap [7] = '{SV ? 32'h0E : 32'h00, 32'h0E, 32'h0E, 32'h0E,
        SV ? 32'h07 : 32'h00, 32'h0F, 32'h07};

    frb_bank_top #(.SECOND_VARIANT(SV)) dut (.*);
    frb_host_model host (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge hung) begin
        n_errors++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r, r2;
        int k;
        sys_rst = 1'b1;
        void'($urandom(32'hFDC13123));
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (caps[i]) begin
            host.rd(caps[i] | 12'($urandom_range(3)), d, r);
            `CHK(d, exp_cap[i])
            `CHK(r, FRB_RESP_OKAY)
        end
        $display("test table read done");
        repeat (12) begin
            k = $urandom_range(6);
            fork
                host.wr(caps[k], $urandom, 4'($urandom), r);
                host.rd(caps[k], d, r2);
            join
            cnt++;
            `CHK(r, FRB_RESP_OKAY)
            `CHK(r2, FRB_RESP_OKAY)
            `CHK(d, exp_cap[k])
        end
        host.rd(FRB_OFF_STAT, d, r);
        `CHK(d, {15'h0000, SV, 16'(cnt)})
        $display("test dropped writes done");
        host.rd(12'h230, d, r);
        `CHK(d, 32'h00000000)
        `CHK(r, FRB_RESP_OKAY)
        host.wr(FRB_OFF_CTRL, 32'h00000001, 4'h1, r);
        host.rd(12'h244, d, r);
        `CHK(r, FRB_RESP_DECERR)
        `CHK(d, 32'h00000000)
        host.wr(12'h244, 32'h00000000, 4'hF, r);
        `CHK(r, FRB_RESP_DECERR)
        host.wr(12'h258, 32'hFFFFFFFF, 4'hF, r);
        `CHK(r, FRB_RESP_OKAY)
        host.wr(FRB_OFF_CTRL, 32'h00000002, 4'h1, r);
        host.rd(FRB_OFF_STAT, d, r);
        `CHK(d, {15'h0000, SV, 16'h0000})
        $display("test unmapped and strict done");
        results();
    end
endmodule
